// file: common/sbsr_pkg.sv
// Shared constants for the status byte and service request block
package sbsr_pkg;
  // ----------------------------------------
  // Status byte bit positions
  // ----------------------------------------
  localparam int BIT_B0 = 0;
  localparam int BIT_ERR = 2;
  localparam int BIT_QUES = 3;
  localparam int BIT_MSG = 4;
  localparam int BIT_STD_EVT = 5;
  localparam int BIT_SERVICE = 6;
  localparam int BIT_B7 = 7;
  // ----------------------------------------
  // Widths, depths, reset values
  // ----------------------------------------
  localparam int SB_W = 8;
  localparam int QUES_W = 16;
  localparam int ERR_DEPTH = 10;
  localparam int OUT_DEPTH = 4;
  localparam int MSG_W = 16;
  localparam logic [7:0] SUMMARY_MASK = 8'hBF;
  localparam logic [7:0] MASK_RESET = 8'h00;
endpackage

// file: src/sbsr_fifo.sv
// Simple message FIFO that drops writes when full
module sbsr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 10
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic i_clr,
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_data,
  output logic o_empty,
  output logic o_full
);
  localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
    $error("sbsr_fifo: bad size");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] wr_reg;
  logic [CW-1:0] cnt_reg;
  logic do_push;
  logic do_pop;

  // Full FIFO keeps stored entries, new ones are lost
  assign do_push = i_push && (cnt_reg != CW'(DEPTH));
  assign do_pop = i_pop && (cnt_reg != '0);
  assign o_empty = (cnt_reg == '0);
  assign o_full = (cnt_reg == CW'(DEPTH));
  assign o_data = mem[rd_reg];

  always_ff @(posedge I_SYS_CLK) begin
    if (i_clr && i_push) begin
      mem[0] <= i_data;
    end else if (do_push) begin
      mem[wr_reg] <= i_data;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rd_reg <= '0;
      wr_reg <= '0;
      cnt_reg <= '0;
    end else if (i_clr) begin
      // A push in the clearing cycle is kept: the set wins over the clear
      rd_reg <= '0;
      wr_reg <= (i_push && DEPTH > 1) ? AW'(1) : '0;
      cnt_reg <= i_push ? CW'(1) : '0;
    end else begin
      if (do_push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// file: src/sbsr_request.sv
// Service request edge detect, request flag and bus line driver
module sbsr_request (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic [7:0] i_enabled,
  input wire logic i_poll,
  output logic o_req_flag,
  output logic o_srq
);
  logic [7:0] prev_reg;
  logic rise;

  assign rise = |(i_enabled & ~prev_reg);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      prev_reg <= 8'h00;
    end else begin
      prev_reg <= i_enabled;
    end
  end

  // A new rise in the poll cycle wins over the poll clear
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      o_req_flag <= 1'b0;
      o_srq <= 1'b0;
    end else if (rise) begin
      o_req_flag <= 1'b1; // see (RL11)
      o_srq <= 1'b1;
    end else if (i_poll) begin
      o_req_flag <= 1'b0; // see (RL12)
      o_srq <= 1'b0;
    end
  end
endmodule

// file: src/sbsr_top.sv
// Status byte, service request mask and message queues of the bus port
//
// Operation
// (RL1) Query responses queued; message flag while nonempty
// (RL2) Read removes message; flag clears when empty
// (RL3) Controller queries first, then reads as talker
// (RL4) Error queue holds ten entries, in order
// (RL5) Error append sets flag; empty clears it
// (RL6) Either error query read removes oldest
// (RL7) Status byte and mask are eight bits
// (RL8) Summary bits mirror inputs, never latched
// (RL9) Master summary is OR of masked bits
// (RL10) Status query returns master summary, no clear
// (RL11) Enabled summary rise sets request, asserts line
// (RL12) Serial poll returns request flag, clears it
// (RL13) New request possible after poll, same source
// (RL14) Poll leaves master summary until bits zero
// (RL15) Clear-status clears status byte bits; here the error and message bits via the queues and the request flag; a same-cycle push keeps its bit set
// (RL16) Mask written, read back, zero on reset
// (RL17) Questionable summary is OR of masked latches
// (RL18) Full error queue drops new messages
module sbsr_top #(
  parameter int MSG_W = sbsr_pkg::MSG_W,
  parameter int ERR_DEPTH = sbsr_pkg::ERR_DEPTH,
  parameter int OUT_DEPTH = sbsr_pkg::OUT_DEPTH
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic I_SB_B0,
  input wire logic I_SB_B7,
  input wire logic I_STANDARD_EVENT_SUMMARY_FLAG,
  input wire logic [sbsr_pkg::QUES_W-1:0] I_QUES_EVENT,
  input wire logic [sbsr_pkg::QUES_W-1:0] I_QUES_ENABLE,
  input wire logic I_RESP_PUSH,
  input wire logic [MSG_W-1:0] I_RESP_DATA,
  input wire logic I_TALK_READ,
  input wire logic I_ERR_PUSH,
  input wire logic [MSG_W-1:0] I_ERR_DATA,
  input wire logic I_ERR_READ,
  input wire logic I_STB_QUERY,
  input wire logic I_SERIAL_POLL,
  input wire logic I_CLEAR_STATUS,
  input wire logic I_MASK_WRITE,
  input wire logic [7:0] I_MASK_DATA,
  input wire logic I_MASK_QUERY,
  output logic [7:0] O_REPLY,
  output logic O_REPLY_VALID,
  output logic [MSG_W-1:0] O_MSG_DATA,
  output logic O_MSG_VALID,
  output logic [MSG_W-1:0] O_ERR_DATA,
  output logic O_ERR_VALID,
  output logic O_SRQ,
  output logic O_ERR_FULL
);
  if (ERR_DEPTH < 1 || OUT_DEPTH < 1 || MSG_W < 1) begin : g_bad_param
    $error("sbsr_top: bad parameters");
  end

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  logic out_empty;
  logic err_empty;
  logic err_full;
  logic [MSG_W-1:0] out_head;
  logic [MSG_W-1:0] err_head;
  logic out_pop;
  logic err_pop;

  assign out_pop = I_TALK_READ && !out_empty; // see (RL2) (RL3)
  assign err_pop = I_ERR_READ && !err_empty; // see (RL6)

  // Output queue is flushed by clear-status: the message flag clears unless a response is pushed in that cycle
  sbsr_fifo #(.WIDTH(MSG_W), .DEPTH(OUT_DEPTH)) u_out (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RST_B(I_RST_B),
    .i_clr(I_CLEAR_STATUS), // see (RL15)
    .i_push(I_RESP_PUSH), // see (RL1)
    .i_data(I_RESP_DATA),
    .i_pop(out_pop),
    .o_data(out_head),
    .o_empty(out_empty),
    .o_full()
  );

  sbsr_fifo #(.WIDTH(MSG_W), .DEPTH(ERR_DEPTH)) u_err (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RST_B(I_RST_B),
    .i_clr(I_CLEAR_STATUS),
    .i_push(I_ERR_PUSH), // see (RL4) (RL18)
    .i_data(I_ERR_DATA),
    .i_pop(err_pop),
    .o_data(err_head),
    .o_empty(err_empty),
    .o_full(err_full)
  );

  // ----------------------------------------
  // Status byte and mask
  // ----------------------------------------
  logic [7:0] mask_reg;
  logic ques_summary;
  logic [7:0] status_byte;
  logic [7:0] enabled;
  logic master_summary_flag;
  logic request_service_flag;

  assign ques_summary = |(I_QUES_EVENT & I_QUES_ENABLE); // see (RL17)

  // Combinational: upstream clears show at once, no latching
  always_comb begin
    status_byte = 8'h00; // see (RL7)
    status_byte[sbsr_pkg::BIT_B0] = I_SB_B0; // see (RL8)
    status_byte[sbsr_pkg::BIT_ERR] = !err_empty; // see (RL5)
    status_byte[sbsr_pkg::BIT_QUES] = ques_summary;
    status_byte[sbsr_pkg::BIT_MSG] = !out_empty; // see (RL1)
    status_byte[sbsr_pkg::BIT_STD_EVT] = I_STANDARD_EVENT_SUMMARY_FLAG;
    status_byte[sbsr_pkg::BIT_B7] = I_SB_B7;
  end

  assign enabled = status_byte & mask_reg & sbsr_pkg::SUMMARY_MASK;
  assign master_summary_flag = |enabled; // see (RL9) (RL14)

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mask_reg <= sbsr_pkg::MASK_RESET;
    end else if (I_MASK_WRITE) begin
      mask_reg <= I_MASK_DATA; // see (RL16)
    end
  end

  // ----------------------------------------
  // Service request
  // ----------------------------------------
  // Rise is tracked per enabled bit, so a polled-away request can be
  // raised again by any later rise of the same source
  // Clear-status drops a pending request along with the error and message queues
  sbsr_request u_req (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RST_B(I_RST_B),
    .i_enabled(enabled),
    .i_poll(I_SERIAL_POLL || I_CLEAR_STATUS), // see (RL12) (RL13) (RL15)
    .o_req_flag(request_service_flag),
    .o_srq(O_SRQ) // see (RL11)
  );

  // ----------------------------------------
  // Replies
  // ----------------------------------------
  // Priority: serial poll, status query, mask query
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_REPLY <= 8'h00;
      O_REPLY_VALID <= 1'b0;
    end else if (I_SERIAL_POLL) begin
      O_REPLY <= {status_byte[7], request_service_flag,
        status_byte[5:0]}; // see (RL12)
      O_REPLY_VALID <= 1'b1;
    end else if (I_STB_QUERY) begin
      O_REPLY <= {status_byte[7], master_summary_flag,
        status_byte[5:0]}; // see (RL10)
      O_REPLY_VALID <= 1'b1;
    end else if (I_MASK_QUERY) begin
      O_REPLY <= mask_reg; // see (RL16)
      O_REPLY_VALID <= 1'b1;
    end else begin
      O_REPLY_VALID <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_MSG_DATA <= '0;
      O_MSG_VALID <= 1'b0;
      O_ERR_DATA <= '0;
      O_ERR_VALID <= 1'b0;
      O_ERR_FULL <= 1'b0;
    end else begin
      O_MSG_VALID <= out_pop;
      if (out_pop) begin
        O_MSG_DATA <= out_head;
      end
      O_ERR_VALID <= err_pop;
      if (err_pop) begin
        O_ERR_DATA <= err_head;
      end
      O_ERR_FULL <= err_full;
    end
  end
endmodule

// file: bench/sbsr_top_asserts.sv
// Port assertions for the status byte block
module sbsr_chk (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  input wire logic I_SB_B0,
  input wire logic I_SB_B7,
  input wire logic I_STANDARD_EVENT_SUMMARY_FLAG,
  input wire logic [15:0] I_QUES_EVENT,
  input wire logic [15:0] I_QUES_ENABLE,
  input wire logic I_TALK_READ,
  input wire logic I_ERR_READ,
  input wire logic I_STB_QUERY,
  input wire logic I_SERIAL_POLL,
  input wire logic I_CLEAR_STATUS,
  input wire logic I_MASK_WRITE,
  input wire logic I_MASK_QUERY,
  input wire logic [7:0] O_REPLY,
  input wire logic O_REPLY_VALID,
  input wire logic O_MSG_VALID,
  input wire logic O_ERR_VALID,
  input wire logic O_SRQ,
  input wire logic O_ERR_FULL
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);
  logic qs;
  logic stb;
  assign qs = |(I_QUES_EVENT & I_QUES_ENABLE);
  // Poll wins over a status query in the same cycle
  assign stb = I_STB_QUERY && !I_SERIAL_POLL;
  // ----
  // Checks
  // ----
  reply_due_a:
    assert property ((stb || I_SERIAL_POLL || I_MASK_QUERY)
      |=> O_REPLY_VALID) else $error("reply missing");
  mirror_bits_a:
    assert property (stb |=> O_REPLY[0] == $past(I_SB_B0) && !O_REPLY[1]
      && O_REPLY[7] == $past(I_SB_B7)
      && O_REPLY[5] == $past(I_STANDARD_EVENT_SUMMARY_FLAG))
      else $error("summary bit wrong");
  ques_sum_a:
    assert property (stb |=> O_REPLY[3] == $past(qs))
      else $error("questionable bit wrong");
  poll_flag_a:
    assert property (I_SERIAL_POLL && O_SRQ |=> O_REPLY[6])
      else $error("poll reply lacks request flag");
  srq_hold_a:
    assert property (O_SRQ && !I_SERIAL_POLL && !I_CLEAR_STATUS
      && !I_MASK_WRITE |=> O_SRQ) else $error("request line dropped");
  msg_pop_a:
    assert property (O_MSG_VALID |-> $past(I_TALK_READ))
      else $error("message without read");
  err_pop_a:
    assert property (O_ERR_VALID |-> $past(I_ERR_READ))
      else $error("error entry without read");
  err_keep_a:
    assert property (O_ERR_FULL && !I_ERR_READ && !$past(I_ERR_READ)
      && !I_CLEAR_STATUS && !$past(I_CLEAR_STATUS) |=> O_ERR_FULL)
      else $error("full error queue lost entry");
  poll_c: cover property (I_SERIAL_POLL && O_SRQ);
  full_c: cover property (O_ERR_FULL && I_ERR_READ);
  mask_c: cover property (I_MASK_WRITE ##1 I_MASK_QUERY);
endmodule

bind sbsr_top sbsr_chk u_chk (.*);

// file: bench/sbsr_host.sv
// Bus controller model that serial polls on a service request
module sbsr_host #(
  parameter int DLY = 3
) (
  input wire logic i_clk,
  input wire logic i_auto,
  input wire logic i_srq,
  input wire logic [7:0] i_reply,
  input wire logic i_valid,
  output logic o_poll,
  output logic [7:0] o_stat
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_c;
  // A slow host: the line must stand DLY cycles before it polls
  initial begin
    o_poll = 1'b0;
    o_stat = 8'h00;
    wait_c = 0;
    forever begin
      @(posedge i_clk);
      #1;
      if (o_poll) begin
        o_poll = 1'b0;
        if (i_valid) o_stat = i_reply;
      end else if (i_auto && i_srq) begin
        o_poll = wait_c == DLY;
        wait_c = o_poll ? 0 : wait_c + 1;
      end
    end
  end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the status byte block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, b0, b7, sev, rp, tr, ep, er, sq, cs, mw, mq, auto;
  logic rv, mv, ev, srq, full, poll;
  logic [15:0] qev, qen, rd, ed, msgd, errd;
  logic [7:0] md, rep, stat, r;
  logic [50:0] rows [5];
  int fail_count = 0;
  int cmp_count = 0;
  int i;
  sbsr_top u_dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_SB_B0(b0),
    .I_SB_B7(b7), .I_STANDARD_EVENT_SUMMARY_FLAG(sev), .I_QUES_EVENT(qev),
    .I_QUES_ENABLE(qen), .I_RESP_PUSH(rp), .I_RESP_DATA(rd),
    .I_TALK_READ(tr), .I_ERR_PUSH(ep), .I_ERR_DATA(ed), .I_ERR_READ(er),
    .I_STB_QUERY(sq), .I_SERIAL_POLL(poll), .I_CLEAR_STATUS(cs),
    .I_MASK_WRITE(mw), .I_MASK_DATA(md), .I_MASK_QUERY(mq), .O_REPLY(rep),
    .O_REPLY_VALID(rv), .O_MSG_DATA(msgd), .O_MSG_VALID(mv),
    .O_ERR_DATA(errd), .O_ERR_VALID(ev), .O_SRQ(srq), .O_ERR_FULL(full));
  sbsr_host u_host (.i_clk(clk), .i_auto(auto), .i_srq(srq), .i_reply(rep),
    .i_valid(rv), .o_poll(poll), .o_stat(stat));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ask(logic m);
    if (m) mq = 1;
    else sq = 1;
    cyc();
    if (m) mq = 0;
    else sq = 0;
    r = rep;
    chk("reply valid", rv, 1);
  endtask
  task automatic setm(logic [7:0] m);
    md = m;
    mw = 1;
    cyc();
    mw = 0;
  endtask
  task automatic srvc(logic [7:0] e);
    auto = 1;
    cyc(8);
    auto = 0;
    chk("poll reply", stat, e);
    chk("line after poll", srq, 0);
  endtask
  task automatic fill(logic e, int n, logic [15:0] b);
    rp = !e;
    ep = e;
    for (i = 0; i < n; i++) begin
      rd = b + 16'(i);
      ed = b + 16'(i);
      cyc();
    end
    rp = 0;
    ep = 0;
  endtask
  // One pop beyond the stored count checks the refusal on empty
  task automatic drain(logic e, int n, logic [15:0] b);
    tr = !e;
    er = e;
    for (i = 0; i <= n; i++) begin
      cyc();
      chk("pop valid", e ? ev : mv, 16'(i < n));
      if (i < n) chk("pop data", e ? errd : msgd, b + 16'(i));
    end
    tr = 0;
    er = 0;
  endtask
  initial begin
    clk = 0;
    forever #2.5 clk = !clk;
  end
  initial begin
    #5000;
    fail_count++;
    give_verdict();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {b0, b7, sev, rp, tr, ep, er, sq, cs, mw, mq, auto} = '0;
    {qev, qen, rd, ed, md} = '0;
    rst_b = 0;
    rows[0] = {8'h00, 16'h0001, 16'h0001, 3'b000, 8'h08};
    rows[1] = {8'h08, 16'h0001, 16'h0001, 3'b000, 8'h48};
    rows[2] = {8'h01, 16'h0100, 16'h0010, 3'b001, 8'h41};
    rows[3] = {8'h80, 16'h0000, 16'hFFFF, 3'b110, 8'hE0};
    rows[4] = {8'h40, 16'h0000, 16'h0000, 3'b010, 8'h20};
    cyc(20);
    rst_b = 1;
    ask(1);
    chk("mask at reset", r, 0);
    for (i = 0; i < 5; i++) begin
      setm(rows[i][50:43]);
      {qev, qen, b7, sev, b0} = rows[i][42:8];
      ask(1);
      chk("mask", r, rows[i][50:43]);
      ask(0);
      chk("status byte", r, rows[i][7:0]);
    end
    srvc(8'h60);
    {qev, qen, b7, sev, b0} = '0;
    setm(8'h20);
    sev = 1;
    cyc();
    chk("request line", srq, 1);
    srvc(8'h60);
    ask(0);
    chk("summary kept", r, 8'h60);
    sev = 0;
    cyc();
    sev = 1;
    cyc();
    chk("request again", srq, 1);
    srvc(8'h60);
    sev = 0;
    ask(0);
    chk("summary gone", r, 0);
    fill(0, 3, 16'h00A0);
    ask(0);
    chk("message flag", r, 8'h10);
    drain(0, 3, 16'h00A0);
    ask(0);
    chk("message flag", r, 0);
    fill(1, 12, 16'h0E00);
    chk("error full", full, 1);
    ask(0);
    chk("error flag", r, 8'h04);
    drain(1, 10, 16'h0E00);
    ask(0);
    chk("error flag", r, 0);
    setm(8'h04);
    rp = 1;
    ep = 1;
    cyc();
    {rp, ep} = '0;
    cyc();
    chk("request on error", srq, 1);
    cs = 1;
    cyc();
    cs = 0;
    chk("line cleared", srq, 0);
    ask(0);
    chk("cleared byte", r, 0);
    // A push in the clearing cycle must survive the clear
    ep = 1;
    cs = 1;
    cyc();
    {ep, cs} = '0;
    ask(0);
    chk("push beats clear", r, 8'h44);
    chk("request on push", srq, 1);
    // Reset in mid-run
    rst_b = 0;
    cyc();
    chk("line in reset", srq, 0);
    chk("reply in reset", rv, 0);
    rst_b = 1;
    ask(0);
    chk("byte after reset", r, 0);
    ask(1);
    chk("mask after reset", r, 0);
    give_verdict();
  end
endmodule
